// ===== rps_defines.svh
`ifndef RPS_DEFINES_SVH
`define RPS_DEFINES_SVH
// Timing
`define RPS_CLK_MHZ 125
`define RPS_BIT_KBPS 50
`define RPS_CHIP_KBPS 100
`define RPS_CHIP_CYC ((`RPS_CLK_MHZ * 1000) / `RPS_CHIP_KBPS)
`define RPS_PREAMBLE_US 200
`define RPS_PRE_BITS ((`RPS_PREAMBLE_US * `RPS_BIT_KBPS) / 1000)
`define RPS_FRAME_BITS (`RPS_PRE_BITS + 72)
`define RPS_HCLK_HALF 125
// Frame contents
`define RPS_PREAMBLE 10'h2AA
`define RPS_CRC_POLY 8'h07
// Tuning relation in kHz
`define RPS_BASE_KHZ 20'h67200
`define RPS_STEP_KHZ 20'h00064
// Amplifier power codes in dBm, two's complement
`define RPS_PA0 8'hF6
`define RPS_PA1 8'hFE
`define RPS_PA2 8'h06
`define RPS_PA3 8'h0A
// Register byte addresses
`define RPS_A_CTRL 8'h00
`define RPS_A_TXADDR 8'h04
`define RPS_A_RXADDR 8'h08
`define RPS_A_TXPAY 8'h0C
`define RPS_A_RXPAY 8'h10
`define RPS_A_STATUS 8'h14
`define RPS_A_IRQST 8'h18
`define RPS_A_IRQMSK 8'h1C
`define RPS_A_FREQ 8'h20
`define RPS_A_PA 8'h24
// Reset values
`define RPS_CTRL_RST 14'h206C
`define RPS_ADDR_RST 32'hE7E7E7E7
`endif

// ===== rps_pkg.sv
package rps_pkg;
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} rps_tx_state_type;
  typedef enum logic [2:0] {RX_OFF = 3'b001, RX_HUNT = 3'b010, RX_BODY = 3'b100} rps_rx_state_type;
  typedef struct packed {
    logic ce;
    logic txsel;
    logic pwr;
    logic lclk;
    logic ldat;
  } rps_pins_type;
  typedef struct packed {
    logic clk_en;
    logic auto_rt;
    logic [1:0] pa;
    logic band;
    logic [8:0] ch;
  } rps_ctrl_type;
endpackage

// ===== rps_top.sv
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`include "rps_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module rps_top
  import rps_pkg::*;
#(
  parameter int CHIP_CYC = `RPS_CHIP_CYC,
  parameter int HCLK_HALF = `RPS_HCLK_HALF
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic radio_chip_enable,
  input wire logic transmit_select,
  input wire logic power_up_pin,
  input wire logic link_clk,
  input wire logic link_rx_chip,
  output logic tx_chip_out,
  output logic tx_active,
  output logic packet_ready_flag,
  output logic address_match_flag,
  output logic host_clk_out,
  output logic irq
);
  localparam int FR = `RPS_FRAME_BITS;
  localparam int CW = $clog2(CHIP_CYC);
  localparam int HW = $clog2(HCLK_HALF + 1);
  if (CHIP_CYC < 2 || HCLK_HALF < 1) begin : g_bad_param
    $error("rps_top: CHIP_CYC must be >= 2 and HCLK_HALF >= 1");
  end

  // CRC over address and payload, MSB first
  function automatic logic [7:0] crc8(input logic [63:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 63; i >= 0; i--)
    begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ `RPS_CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic [4:0] s1_q, s2_q, s3_q, pin_q;
  rps_pins_type pins;
  assign pins = pin_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
      s3_q <= 5'h00;
    end
    else
    begin
      s1_q <= {radio_chip_enable, transmit_select, power_up_pin, link_clk, link_rx_chip};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // A change counts once the second and third stages agree
  for (genvar i = 0; i < 5; i++)
  begin : g_filt
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        pin_q[i] <= 1'b0;
      else if (s2_q[i] == s3_q[i])
        pin_q[i] <= s3_q[i];
    end
  end

  // Edge history and mode decode
  logic ce_prev_q, lclk_prev_q, pwr_prev_q, txsel_prev_q, txm_prev_q;
  wire tx_mode = pins.pwr & pins.txsel;
  wire rx_mode = pins.pwr & pins.ce & ~pins.txsel;
  wire ce_rise = pins.ce & ~ce_prev_q;
  wire lclk_rise = pins.lclk & ~lclk_prev_q;
  wire rx_wipe = (pwr_prev_q & ~pins.pwr) | (pins.txsel & ~txsel_prev_q);
  wire mode_chg = tx_mode ^ txm_prev_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      {ce_prev_q, lclk_prev_q, pwr_prev_q, txsel_prev_q, txm_prev_q} <= 5'h00;
    else
      {ce_prev_q, lclk_prev_q, pwr_prev_q, txsel_prev_q, txm_prev_q} <=
        {pins.ce, pins.lclk, pins.pwr, pins.txsel, tx_mode};
  end

  // ==========================================================
  // Registers
  rps_ctrl_type ctrl_q;
  logic [31:0] tx_addr_q, rx_addr_q, tx_pay_q, rx_pay_q;
  logic [3:0] irq_st_q, mask_q;
  logic [19:0] freq_q;
  logic [7:0] pa_q;
  logic ready_q, am_q;

  // ==========================================================
  // Transmit frame engine
  rps_tx_state_type tx_st_q;
  logic [FR-1:0] frame_q;
  logic [6:0] bit_cnt_q;
  logic [CW-1:0] chip_cnt_q;
  logic phase_q;
  wire [FR-1:0] frame_new = {`RPS_PREAMBLE, tx_addr_q, tx_pay_q, crc8({tx_addr_q, tx_pay_q})};
  wire chip_end = chip_cnt_q == CW'(CHIP_CYC - 1);
  wire frame_end = (tx_st_q == TX_SEND) && chip_end && phase_q && (bit_cnt_q == 7'(FR - 1));
  wire tx_start = (tx_st_q == TX_IDLE) && tx_mode && ce_rise;
  wire tx_again = frame_end && ctrl_q.auto_rt && pins.ce && tx_mode;
  wire tx_chip_d = (tx_st_q == TX_SEND) & (frame_q[FR-1] ^ phase_q);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_st_q <= TX_IDLE;
      frame_q <= '0;
      bit_cnt_q <= 7'h00;
      chip_cnt_q <= '0;
      phase_q <= 1'b0;
    end
    else if (tx_start || tx_again)
    begin
      tx_st_q <= TX_SEND;
      frame_q <= frame_new;
      bit_cnt_q <= 7'h00;
      chip_cnt_q <= '0;
      phase_q <= 1'b0;
    end
    else if (frame_end)
      tx_st_q <= TX_IDLE;
    else if (tx_st_q == TX_SEND && chip_end)
    begin
      chip_cnt_q <= '0;
      phase_q <= ~phase_q;
      if (phase_q)
      begin
        bit_cnt_q <= bit_cnt_q + 7'h01;
        frame_q <= {frame_q[FR-2:0], 1'b0};
      end
    end
    else if (tx_st_q == TX_SEND)
      chip_cnt_q <= chip_cnt_q + CW'(1);
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      {tx_chip_out, tx_active} <= 2'b00;
    else
      {tx_chip_out, tx_active} <= {tx_chip_d, tx_st_q == TX_SEND};
  end

  // ==========================================================
  // Receive decoder: chip pairs from sampled link clock
  rps_rx_state_type rx_st_q;
  logic chip_hold_q, chip_ph_q;
  logic [31:0] hunt_q;
  logic [38:0] body_q;
  logic [5:0] body_cnt_q;
  wire rx_bit_ev = lclk_rise & rx_mode & chip_ph_q;
  wire bad_pair = chip_hold_q == pins.ldat;
  wire [39:0] body_full = {body_q, chip_hold_q};
  wire body_last = rx_bit_ev && (rx_st_q == RX_BODY) && (body_cnt_q == 6'h27);
  wire crc_good = crc8({rx_addr_q, body_full[39:8]}) == body_full[7:0];
  wire rx_ok_ev = body_last && !bad_pair && crc_good;
  wire crc_fail_ev = rx_bit_ev && (rx_st_q == RX_BODY) && (bad_pair || (body_last && !crc_good));
  wire am_ev = rx_bit_ev && (rx_st_q == RX_HUNT) && ({hunt_q[30:0], chip_hold_q} == rx_addr_q);
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !rx_mode)
    begin
      rx_st_q <= RX_OFF;
      chip_ph_q <= 1'b0;
      chip_hold_q <= 1'b0;
      hunt_q <= 32'h00000000;
      body_q <= '0;
      body_cnt_q <= 6'h00;
    end
    else
    begin
      if (rx_st_q == RX_OFF)
        rx_st_q <= RX_HUNT;
      if (lclk_rise)
      begin
        chip_ph_q <= ~chip_ph_q;
        if (!chip_ph_q)
          chip_hold_q <= pins.ldat;
      end
      if (am_ev)
      begin
        rx_st_q <= RX_BODY;
        body_cnt_q <= 6'h00;
      end
      else if (rx_ok_ev || crc_fail_ev)
        rx_st_q <= RX_HUNT;
      else if (rx_bit_ev && rx_st_q == RX_BODY)
      begin
        body_q <= body_full[38:0];
        body_cnt_q <= body_cnt_q + 6'h01;
      end
      if (rx_bit_ev)
        hunt_q <= {hunt_q[30:0], chip_hold_q};
    end
  end

  // ==========================================================
  // AXI4-Lite slave
  logic aw_hold_q, w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  wire aw_take = awvalid & awready;
  wire w_take = wvalid & wready;
  wire wr_go = aw_hold_q & w_hold_q & ~bvalid;
  wire aw_hold_d = (aw_hold_q | aw_take) & ~wr_go;
  wire w_hold_d = (w_hold_q | w_take) & ~wr_go;
  wire rd_go = arvalid & arready;
  wire rd_rxpay = rd_go && (araddr == `RPS_A_RXPAY);
  wire rd_irq = rd_go && (araddr == `RPS_A_IRQST);
  // Byte-lane mask and per-register write strobes
  logic [31:0] wmask;
  for (genvar b = 0; b < 4; b++)
  begin : g_lane
    assign wmask[8*b +: 8] = {8{wstrb_q[b]}};
  end
  wire [31:0] ctrl_word = {18'h00000, ctrl_q};
  wire wr_ctrl = wr_go && (awaddr_q == `RPS_A_CTRL);
  wire wr_txa = wr_go && (awaddr_q == `RPS_A_TXADDR);
  wire wr_rxa = wr_go && (awaddr_q == `RPS_A_RXADDR);
  wire wr_txp = wr_go && (awaddr_q == `RPS_A_TXPAY);
  wire wr_msk = wr_go && (awaddr_q == `RPS_A_IRQMSK);
  wire wr_ok = wr_ctrl | wr_txa | wr_rxa | wr_txp | wr_msk;
  wire [31:0] ctrl_m = (ctrl_word & ~wmask) | (wdata_q & wmask);
  wire [31:0] txa_m = (tx_addr_q & ~wmask) | (wdata_q & wmask);
  wire [31:0] rxa_m = (rx_addr_q & ~wmask) | (wdata_q & wmask);
  wire [31:0] txp_m = (tx_pay_q & ~wmask) | (wdata_q & wmask);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {aw_hold_q, w_hold_q, awready, wready, bvalid} <= 5'h00;
      bresp <= 2'b00;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end
    else
    begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awready <= ~aw_hold_d;
      wready <= ~w_hold_d;
      if (aw_take)
        awaddr_q <= awaddr;
      if (w_take)
        {wdata_q, wstrb_q} <= {wdata, wstrb};
      if (wr_go)
        {bvalid, bresp} <= {1'b1, wr_ok ? 2'b00 : 2'b10};
      else if (bready)
        bvalid <= 1'b0;
    end
  end
  // Read data selection
  wire [31:0] rd_mux =
    (araddr == `RPS_A_CTRL) ? ctrl_word :
    (araddr == `RPS_A_TXADDR) ? tx_addr_q :
    (araddr == `RPS_A_RXADDR) ? rx_addr_q :
    (araddr == `RPS_A_TXPAY) ? tx_pay_q :
    (araddr == `RPS_A_RXPAY) ? rx_pay_q :
    (araddr == `RPS_A_STATUS) ? {27'h0, rx_mode, tx_mode, tx_st_q == TX_SEND, am_q, ready_q} :
    (araddr == `RPS_A_IRQST) ? {28'h0, irq_st_q} :
    (araddr == `RPS_A_IRQMSK) ? {28'h0, mask_q} :
    (araddr == `RPS_A_FREQ) ? {12'h000, freq_q} :
    (araddr == `RPS_A_PA) ? {24'h000000, pa_q} : 32'h00000000;
  wire rd_map = (araddr[1:0] == 2'b00) && (araddr <= `RPS_A_PA);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {arready, rvalid} <= 2'b00;
      rdata <= 32'h00000000;
      rresp <= 2'b00;
    end
    else if (rd_go)
    begin
      {arready, rvalid} <= 2'b01;
      rdata <= rd_mux;
      rresp <= rd_map ? 2'b00 : 2'b10;
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
    else if (!rvalid)
      arready <= 1'b1;
  end

  // ==========================================================
  // Configuration store, tuning and amplifier decode
  wire [19:0] f_lo = `RPS_BASE_KHZ + 20'(ctrl_q.ch) * `RPS_STEP_KHZ;
  wire [19:0] freq_d = ctrl_q.band ? {f_lo[18:0], 1'b0} : f_lo;
  wire [7:0] pa_d = (ctrl_q.pa == 2'b00) ? `RPS_PA0 : (ctrl_q.pa == 2'b01) ? `RPS_PA1 :
                    (ctrl_q.pa == 2'b10) ? `RPS_PA2 : `RPS_PA3;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= `RPS_CTRL_RST;
      {tx_addr_q, rx_addr_q} <= {`RPS_ADDR_RST, `RPS_ADDR_RST};
      tx_pay_q <= 32'h00000000;
      mask_q <= 4'h0;
      freq_q <= 20'h00000;
      pa_q <= 8'h00;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= ctrl_m[13:0];
      if (wr_txa)
        tx_addr_q <= txa_m;
      if (wr_rxa)
        rx_addr_q <= rxa_m;
      if (wr_txp)
        tx_pay_q <= txp_m;
      if (wr_msk)
        mask_q <= wdata_q[3:0];
      freq_q <= freq_d;
      pa_q <= pa_d;
    end
  end

  // ==========================================================
  // Flags, receive buffer, interrupts, host clock
  wire clr_ready = tx_start | tx_again | mode_chg | rd_rxpay | rx_wipe;
  wire [3:0] ev = {crc_fail_ev, am_ev, rx_ok_ev, frame_end};
  wire [3:0] irq_st_d = (irq_st_q & ~{4{rd_irq}}) | ev;
  logic [HW-1:0] hclk_cnt_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {ready_q, am_q, irq} <= 3'b000;
      rx_pay_q <= 32'h00000000;
      irq_st_q <= 4'h0;
    end
    else
    begin
      ready_q <= frame_end | rx_ok_ev | (ready_q & ~clr_ready);
      am_q <= am_ev | (am_q & ~(rd_rxpay | rx_wipe | crc_fail_ev));
      if (rx_ok_ev)
        rx_pay_q <= body_full[39:8];
      else if (rx_wipe)
        rx_pay_q <= 32'h00000000;
      irq_st_q <= irq_st_d;
      irq <= |(irq_st_d & mask_q);
    end
  end
  assign packet_ready_flag = ready_q;
  assign address_match_flag = am_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !ctrl_q.clk_en)
    begin
      hclk_cnt_q <= '0;
      host_clk_out <= 1'b0;
    end
    else if (hclk_cnt_q == HW'(HCLK_HALF - 1))
    begin
      hclk_cnt_q <= '0;
      host_clk_out <= ~host_clk_out;
    end
    else
      hclk_cnt_q <= hclk_cnt_q + HW'(1);
  end

  // ==========================================================
  // Assertions
  a_tx_standby: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_end && !tx_again |=> tx_st_q == TX_IDLE ##1 !tx_active) else $error("no standby after frame");
  a_retran_repeat: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_again |=> tx_st_q == TX_SEND && bit_cnt_q == 7'h00) else $error("retransmit not restarted");
  a_rx_buffer: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_ok_ev |=> ready_q && rx_pay_q == $past(body_full[39:8])) else $error("ready without packet");
  a_read_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_rxpay && !rx_ok_ev && !am_ev && !frame_end |=> !ready_q && !am_q) else $error("read left flags");
  a_wipe_rx: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_wipe && !rx_ok_ev && !frame_end |=> rx_pay_q == 32'h0 && !ready_q && !am_q) else $error("rx not wiped");
  a_preamble_lead: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_start || tx_again |=> frame_q[FR-1:FR-10] == `RPS_PREAMBLE) else $error("preamble missing");
  a_manchester_chip: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_st_q == TX_SEND |=> tx_chip_out == ($past(frame_q[FR-1]) ^ $past(phase_q))) else $error("bad chip");
  a_crc_tail: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_start || tx_again |=> frame_q[7:0] == crc8(frame_q[71:8])) else $error("crc not appended");
  a_pa_top: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_q.pa == 2'b11 |=> pa_q == `RPS_PA3) else $error("pa decode wrong");
  a_band_double: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_q.band |=> freq_q == 20'(2 * (`RPS_BASE_KHZ + 20'($past(ctrl_q.ch)) * 20'h64))) else $error("freq");
  a_clk_default: assert property (@(posedge aclk)
    $rose(aresetn) |-> ctrl_q.clk_en) else $error("host clock off after reset");
  a_finish_frame: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_st_q == TX_SEND && !frame_end |=> tx_st_q == TX_SEND) else $error("frame aborted");
  a_tx_ready: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_end |=> ready_q) else $error("tx ready not set");
  a_am_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    crc_fail_ev |=> !am_q) else $error("am kept after crc fail");
  a_regen_frame: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_again |=> frame_q == $past(frame_new)) else $error("repeat frame differs");
endmodule
`default_nettype wire

// ===== rps_dummy_never.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== rps_host_link.sv
`timescale 1ns/1ps
`default_nettype none
// ====================================================
// Remote transmitter feeding the receive chip input
module rps_host_link
(
  output var logic link_clk,
  output var logic link_rx_chip
);
  // Link clock stands low between frames
  initial
  begin
    link_clk = 1'b0;
    link_rx_chip = 1'b0;
  end
  // Sends one frame as Manchester chip pairs, 160 ns per chip
  task automatic send(input logic [81:0] f);
    int b;
    int k;
    #37;
    for (b = 81; b >= 0; b--)
    begin
      for (k = 0; k < 2; k++)
      begin
        #40 link_rx_chip = f[b] ^ k[0];
        #40 link_clk = 1'b1;
        #80 link_clk = 1'b0;
      end
    end
    #40 link_rx_chip = ~link_rx_chip; // Released line shows no stale value
  endtask
endmodule
`default_nettype wire

// ===== tb.sv
`include "rps_defines.svh"
`timescale 1ns/1ps
`default_nettype none
// ====================================================
// Bench for the packet sequencer
module tb
  import rps_pkg::*;
;
  localparam int CC = 4;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic radio_chip_enable = 1'b0, transmit_select = 1'b0, power_up_pin = 1'b0;
  wire logic awready, wready, bvalid, arready, rvalid, tx_chip_out, tx_active;
  wire logic packet_ready_flag, address_match_flag, host_clk_out, irq, link_clk, link_rx_chip;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic [1:0] rr;
  logic [1:0] hc;
  logic [163:0] chips, ec;
  logic [81:0] fr;
  logic [7:0] pa_tab [4] = '{8'hF6, 8'hFE, 8'h06, 8'h0A};

  // ====================================================
  // Design, far side and clock
  rps_top #(.CHIP_CYC(CC), .HCLK_HALF(2)) rps_top_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .radio_chip_enable(radio_chip_enable),
    .transmit_select(transmit_select), .power_up_pin(power_up_pin), .link_clk(link_clk),
    .link_rx_chip(link_rx_chip), .tx_chip_out(tx_chip_out), .tx_active(tx_active),
    .packet_ready_flag(packet_ready_flag), .address_match_flag(address_match_flag),
    .host_clk_out(host_clk_out), .irq(irq));
  rps_host_link rps_host_link_inst (.link_clk(link_clk), .link_rx_chip(link_rx_chip));
  always #4 aclk = ~aclk;

  // ====================================================
  // Compare, verdict and bus tasks
  task automatic chk(input string n, input logic [163:0] seen, input logic [163:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task close_out;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk("bresp", bresp, er);
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
    rdr(a);
    chk(n, {rr, rd & m}, {2'b00, e});
  endtask
  task automatic hclk_seen;
    hc = 2'b00;
    repeat (8)
    begin
      @(posedge aclk);
      hc = hc | (host_clk_out ? 2'b10 : 2'b01);
    end
  endtask
  // Preamble, address, payload, CRC8 over address then payload
  function automatic logic [81:0] mkframe(input logic [31:0] a, input logic [31:0] p);
    logic [63:0] v;
    logic [7:0] c;
    v = {a, p};
    c = 8'h00;
    for (int i = 63; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
    return {10'h2AA, a, p, c};
  endfunction

  // Hang guard
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      miscompares++;
      close_out;
    end
  end

  // ====================================================
  // Main sequence
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`RPS_A_CTRL, 32'h3FFF, 32'h206C, "ctrl");
    hclk_seen();
    chk("hclk", hc, 2'b11);
    rchk(`RPS_A_FREQ, 32'hFFFFF, 32'h69C30, "freq");
    for (int k = 0; k < 4; k++)
    begin
      wr(`RPS_A_CTRL, 32'h206C | (32'(k) << 10), 2'b00);
      rchk(`RPS_A_PA, 32'hFF, {24'h0, pa_tab[k]}, "pa");
    end
    wr(`RPS_A_CTRL, 32'h031F, 2'b00);
    rchk(`RPS_A_FREQ, 32'hFFFFF, 32'hDC438, "freq_hi");
    hclk_seen();
    chk("hclk_off", hc, 2'b01);
    wr(`RPS_A_CTRL, 32'h206C, 2'b00);
    rdr(8'h3C);
    chk("unmapped", {rr, rd}, {2'b10, 32'h0});
    wr(`RPS_A_STATUS, 32'h1F, 2'b10);
    // Single frame then standby
    wr(`RPS_A_TXADDR, 32'hA5C30F96, 2'b00);
    wr(`RPS_A_TXPAY, 32'h80017E3C, 2'b00);
    fr = mkframe(32'hA5C30F96, 32'h80017E3C);
    for (int b = 0; b < 82; b++)
      ec[2*b +: 2] = {fr[b], ~fr[b]};
    power_up_pin <= 1'b1;
    transmit_select <= 1'b1;
    repeat (8) @(posedge aclk);
    radio_chip_enable <= 1'b1;
    fork
      begin
        repeat (8) @(posedge aclk);
        radio_chip_enable <= 1'b0;
      end
    join_none
    repeat (3000) if (!tx_active) @(posedge aclk);
    repeat (2) @(posedge aclk);
    for (int i = 163; i >= 0; i--)
    begin
      chips[i] = tx_chip_out;
      repeat (CC) @(posedge aclk);
    end
    chk("frame", chips, ec);
    repeat (6) @(posedge aclk);
    chk("end", {tx_active, packet_ready_flag, irq}, 3'b010);
    wr(`RPS_A_IRQMSK, 32'h1, 2'b00);
    repeat (2) @(posedge aclk);
    chk("irq_on", irq, 1'b1);
    rchk(`RPS_A_IRQST, 32'hF, 32'h1, "irqst");
    repeat (2) @(posedge aclk);
    chk("irq_off", irq, 1'b0);
    repeat (700) @(posedge aclk);
    chk("no_resend", tx_active, 1'b0);
    transmit_select <= 1'b0;
    repeat (8) @(posedge aclk);
    chk("rdy_mode", packet_ready_flag, 1'b0);
    // Automatic retransmission and late enable drop
    wr(`RPS_A_CTRL, 32'h306C, 2'b00);
    transmit_select <= 1'b1;
    repeat (8) @(posedge aclk);
    radio_chip_enable <= 1'b1;
    repeat (3000) if (!tx_active) @(posedge aclk);
    rdr(`RPS_A_IRQST);
    for (int n = 0; n < 2; n++)
    begin
      repeat (700) @(posedge aclk);
      chk("repeat", tx_active, 1'b1);
      rchk(`RPS_A_IRQST, 32'h1, 32'h1, "txdone");
    end
    radio_chip_enable <= 1'b0;
    repeat (20) @(posedge aclk);
    chk("finish", tx_active, 1'b1);
    repeat (700) if (tx_active) @(posedge aclk);
    rchk(`RPS_A_IRQST, 32'h1, 32'h1, "lastdone");
    repeat (700) @(posedge aclk);
    chk("standby", tx_active, 1'b0);
    wr(`RPS_A_CTRL, 32'h206C, 2'b00);
    // Receive: good, bad CRC, good then power down
    wr(`RPS_A_IRQMSK, 32'h2, 2'b00);
    transmit_select <= 1'b0;
    radio_chip_enable <= 1'b1;
    repeat (10) @(posedge aclk);
    fr = mkframe(32'hE7E7E7E7, 32'h5AF01234);
    for (int n = 0; n < 3; n++)
    begin
      fork
        rps_host_link_inst.send(fr ^ {81'h0, n == 1});
      join_none
      repeat (4000) if (!address_match_flag) @(posedge aclk);
      chk("early", {address_match_flag, packet_ready_flag}, 2'b10);
      wait fork;
      repeat (8) @(posedge aclk);
      if (n == 1)
        chk("badcrc", {address_match_flag, packet_ready_flag}, 2'b00);
      else
        chk("good", {address_match_flag, packet_ready_flag, irq}, 3'b111);
      if (n == 0)
      begin
        rchk(`RPS_A_RXPAY, 32'hFFFFFFFF, 32'h5AF01234, "rxpay");
        repeat (2) @(posedge aclk);
        chk("flags_rd", {address_match_flag, packet_ready_flag}, 2'b00);
        rchk(`RPS_A_IRQST, 32'hF, 32'h6, "rx_irqst");
      end
      // Packet still readable once the radio drops to standby
      if (n == 2)
      begin
        radio_chip_enable <= 1'b0;
        repeat (8) @(posedge aclk);
        rchk(`RPS_A_RXPAY, 32'hFFFFFFFF, 32'h5AF01234, "rxpay_sb");
      end
    end
    power_up_pin <= 1'b0;
    repeat (8) @(posedge aclk);
    chk("flags_pd", {address_match_flag, packet_ready_flag}, 2'b00);
    rchk(`RPS_A_RXPAY, 32'hFFFFFFFF, 32'h0, "rx_clr");
    close_out;
  end
endmodule
`default_nettype wire
